// file: rtl/fpc_pkg.sv
package fpc_pkg;
   localparam int unsigned CLK_HZ          = 100_000_000;
   localparam int unsigned SETUP_HOLD_MS   = 2000;
   localparam int unsigned SETUP_HOLD_CYC  = (CLK_HZ / 1000) * SETUP_HOLD_MS;
   localparam int unsigned GUIDE_HOLD_MS   = 3000;
   localparam int unsigned GUIDE_HOLD_CYC  = (CLK_HZ / 1000) * GUIDE_HOLD_MS;
   localparam int unsigned DEBOUNCE_US     = 10000;
   localparam int unsigned DEBOUNCE_CYC    = (CLK_HZ / 1000000) * DEBOUNCE_US;

   localparam logic [4:0]  ADR_CTRL   = 5'h00;
   localparam logic [4:0]  ADR_STATUS = 5'h04;
   localparam logic [4:0]  ADR_COND   = 5'h08;
   localparam logic [4:0]  ADR_EVENT  = 5'h0c;
   localparam logic [4:0]  ADR_SEL    = 5'h10;

   localparam int unsigned CTRL_ANALOG  = 0;
   localparam int unsigned CTRL_THERMAL = 1;
   localparam int unsigned CTRL_READY   = 2;
   localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
   localparam int unsigned COND_ERROR   = 0;
   localparam int unsigned COND_WARN    = 1;
   localparam int unsigned COND_LOOP    = 2;

   localparam int unsigned NBTN     = 6;
   localparam int unsigned B_SETUP  = 0;
   localparam int unsigned B_UP     = 1;
   localparam int unsigned B_DOWN   = 2;
   localparam int unsigned B_ENTER  = 3;
   localparam int unsigned B_RUN    = 4;
   localparam int unsigned B_GUIDE  = 5;

   typedef enum logic [1:0] {
      FPC_KEY_OFF,
      FPC_KEY_PILOT,
      FPC_KEY_LASER
   } fpc_key_t;

   typedef struct packed {
      logic warning;
      logic error;
      logic ready;
      logic laser;
      logic analog;
      logic thermal_mode_lamp;
      logic remote;
      logic pilot;
      logic run;
   } fpc_lamps_t;

   typedef struct packed {
      logic up;
      logic down;
      logic enter;
      logic set_enter;
      logic set_back;
      logic run_toggle;
      logic guide_toggle;
      logic fault_clear;
   } fpc_events_t;
endpackage : fpc_pkg

// file: rtl/fpc_debounce.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_debounce #(
   parameter int unsigned N   = 6,
   parameter int unsigned CYC = 1000000
) (
   input  wire  logic         clock,
   input  wire  logic         rst_n,
   input  wire  logic [N-1:0] raw,
   output logic       [N-1:0] clean
);
   localparam int unsigned W = $clog2(CYC + 1);
   if (CYC < 1) begin : g_bad_cyc
      $error("debounce count must be at least one");
   end
   genvar i;
   for (i = 0; i < N; i++) begin : g_btn
      logic [W-1:0] cnt;
      // a level must persist for the whole window before it is accepted
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            cnt      <= '0;
            clean[i] <= 1'b0;
         end else if (raw[i] == clean[i]) begin
            cnt <= '0;
         end else if (cnt == W'(CYC - 1)) begin
            cnt      <= '0;
            clean[i] <= raw[i];
         end else begin
            cnt <= cnt + W'(1);
         end
      end
   end
endmodule // fpc_debounce
`default_nettype wire

// file: rtl/fpc_hold_timer.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_hold_timer #(
   parameter int unsigned CYC = 200000000
) (
   input  wire  logic clock,
   input  wire  logic rst_n,
   input  wire  logic held,
   output logic       long_hit,
   output logic       released,
   output logic       was_long
);
   localparam int unsigned W = $clog2(CYC + 1);
   if (CYC < 1) begin : g_bad_cyc
      $error("hold count must be at least one");
   end
   logic [W-1:0] cnt;
   logic         held_q;
   // one pulse when the hold threshold is first reached, one on release
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cnt      <= '0;
         held_q   <= 1'b0;
         long_hit <= 1'b0;
         released <= 1'b0;
         was_long <= 1'b0;
      end else begin
         held_q   <= held;
         long_hit <= 1'b0;
         released <= held_q & ~held;
         if (!held) begin
            cnt <= '0;
            if (!held_q) was_long <= 1'b0;
         end else if (cnt != W'(CYC)) begin
            cnt <= cnt + W'(1);
            if (cnt == W'(CYC - 1)) begin
               long_hit <= 1'b1;
               was_long <= 1'b1;
            end
         end
      end
   end
endmodule // fpc_hold_timer
`default_nettype wire

// file: rtl/fpc_panel.sv
// Design decisions made here: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module fpc_panel #(
   parameter int unsigned SETUP_CYC = fpc_pkg::SETUP_HOLD_CYC,
   parameter int unsigned GUIDE_CYC = fpc_pkg::GUIDE_HOLD_CYC,
   parameter int unsigned DEB_CYC   = fpc_pkg::DEBOUNCE_CYC
) (
   input  wire  logic                      clock,
   input  wire  logic                      rst_n,
   input  wire  logic [31:0]               wb_adr_i,
   input  wire  logic [31:0]               wb_dat_i,
   input  wire  logic [3:0]                wb_sel_i,
   input  wire  logic                      wb_we_i,
   input  wire  logic                      wb_cyc_i,
   input  wire  logic                      wb_stb_i,
   output logic       [31:0]               wb_dat_o,
   output logic                            wb_ack_o,
   output logic                            wb_err_o,
   input  wire  fpc_pkg::fpc_key_t         key_pos,
   input  wire  logic                      estop_pressed,
   input  wire  logic                      pilot_switch,
   input  wire  logic                      safety_loop_open,
   input  wire  logic                      error_active,
   input  wire  logic                      warning_active,
   input  wire  logic                      irradiating,
   input  wire  logic [fpc_pkg::NBTN-1:0]  buttons,
   input  wire  logic [11:0]               target_knob,
   output fpc_pkg::fpc_lamps_t             lamps,
   output fpc_pkg::fpc_events_t            events,
   output logic                            laser_drive_power,
   output logic                            laser_enable,
   output logic                            pilot_enable,
   output logic                            settings_mode,
   output logic                            remote_mode,
   output logic                            executing,
   output logic                            guide_light,
   output logic [11:0]                     target_temp,
   output logic [11:0]                     target_power
);
   logic [fpc_pkg::NBTN-1:0] btn;
   logic [fpc_pkg::NBTN-1:0] btn_q;
   logic [fpc_pkg::NBTN-1:0] rise;
   logic                     setup_long;
   logic                     guide_long;
   logic                     guide_rel;
   logic                     guide_was_long;
   logic [31:0]              ctrl;
   logic                     estop_latched;
   logic                     key_seen_off;
   logic                     allow_laser;
   logic                     allow_pilot;
   logic                     next_exec;
   logic                     run_rel;
   logic [31:0]              rd;
   logic                     hit;

   fpc_debounce #(
      .N   (fpc_pkg::NBTN),
      .CYC (DEB_CYC)
   ) u_deb (
      .clock (clock),
      .rst_n (rst_n),
      .raw   (buttons),
      .clean (btn)
   );

   fpc_hold_timer #(
      .CYC (SETUP_CYC)
   ) u_setup (
      .clock    (clock),
      .rst_n    (rst_n),
      .held     (btn[fpc_pkg::B_SETUP] & ~settings_mode),
      .long_hit (setup_long),
      .released (),
      .was_long ()
   );

   fpc_hold_timer #(
      .CYC (GUIDE_CYC)
   ) u_guide (
      .clock    (clock),
      .rst_n    (rst_n),
      .held     (btn[fpc_pkg::B_GUIDE] & ~settings_mode),
      .long_hit (guide_long),
      .released (guide_rel),
      .was_long (guide_was_long)
   );

   always_ff @(posedge clock) begin
      if (!rst_n) btn_q <= '0;
      else        btn_q <= btn;
   end
   assign rise    = btn & ~btn_q;
   assign run_rel = btn_q[fpc_pkg::B_RUN] & ~btn[fpc_pkg::B_RUN];

   // emergency stop latch clears only after release and key off then on
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         estop_latched <= 1'b0;
         key_seen_off  <= 1'b0;
      end else if (estop_pressed) begin
         estop_latched <= 1'b1;
         key_seen_off  <= 1'b0;
      end else if (estop_latched) begin
         if (key_pos == fpc_pkg::FPC_KEY_OFF) key_seen_off <= 1'b1;
         else if (key_seen_off) estop_latched <= 1'b0;
      end
   end

   always_comb begin
      allow_laser = 1'b0;
      allow_pilot = 1'b0;
      case (key_pos)
         fpc_pkg::FPC_KEY_LASER: begin
            allow_laser = ~safety_loop_open & ~error_active;
            allow_pilot = ~safety_loop_open & ~error_active;
         end
         fpc_pkg::FPC_KEY_PILOT: begin
            allow_pilot = ~error_active;
         end
         fpc_pkg::FPC_KEY_OFF: begin
            allow_pilot = 1'b0;
         end
         default: begin
            allow_pilot = 1'b0;
         end
      endcase
      if (estop_latched | estop_pressed) begin
         allow_laser = 1'b0;
         allow_pilot = 1'b0;
      end
   end

   // stopping never waits: loss of permission ends execution at the next clock edge
   always_comb begin
      next_exec = executing;
      if (!allow_laser) next_exec = 1'b0;
      else if (run_rel && !settings_mode && !remote_mode)
         next_exec = ~executing;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         executing         <= 1'b0;
         laser_drive_power <= 1'b0;
         laser_enable      <= 1'b0;
         pilot_enable      <= 1'b0;
      end else begin
         executing         <= next_exec;
         laser_drive_power <= allow_laser;
         laser_enable      <= next_exec;
         pilot_enable      <= allow_pilot & pilot_switch;
      end
   end

   // settings state and local/remote ownership
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         settings_mode <= 1'b0;
         remote_mode   <= 1'b0;
      end else begin
         if (settings_mode && rise[fpc_pkg::B_SETUP])
            settings_mode <= 1'b0;
         else if (setup_long && !executing)
            settings_mode <= 1'b1;
         if (!settings_mode && rise[fpc_pkg::B_ENTER])
            remote_mode <= ~remote_mode;
      end
   end

   // events: one-cycle pulses to the controller's menu logic
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         events <= '0;
      end else begin
         events.up    <= rise[fpc_pkg::B_UP] & (settings_mode | ~remote_mode);
         events.down  <= rise[fpc_pkg::B_DOWN] & (settings_mode | ~remote_mode);
         events.enter <= rise[fpc_pkg::B_ENTER] & ~settings_mode;
         events.set_enter    <= rise[fpc_pkg::B_ENTER] & settings_mode;
         events.set_back     <= rise[fpc_pkg::B_SETUP] & settings_mode;
         events.run_toggle   <= next_exec != executing;
         events.guide_toggle <= guide_rel & ~guide_was_long;
         events.fault_clear  <= guide_long;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) guide_light <= 1'b0;
      else if (guide_rel && !guide_was_long) guide_light <= ~guide_light;
   end

   // knob routed by control mode; the unused target holds its last value
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         target_temp  <= '0;
         target_power <= '0;
      end else if (ctrl[fpc_pkg::CTRL_THERMAL]) begin
         target_temp <= target_knob;
      end else begin
         target_power <= target_knob;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         lamps <= '0;
      end else begin
         lamps.error   <= error_active;
         lamps.warning <= warning_active;
         lamps.ready   <= allow_laser & ctrl[fpc_pkg::CTRL_READY];
         lamps.laser   <= next_exec | irradiating;
         lamps.analog  <= ctrl[fpc_pkg::CTRL_ANALOG];
         lamps.thermal_mode_lamp <= ctrl[fpc_pkg::CTRL_THERMAL];
         lamps.remote  <= remote_mode;
         lamps.pilot   <= allow_pilot & pilot_switch;
         lamps.run     <= next_exec;
      end
   end

   // wishbone classic slave, ack one cycle after strobe, err if unmapped
   assign hit = wb_adr_i[31:5] == '0 && wb_adr_i[1:0] == 2'b00
                && wb_adr_i[4:0] <= fpc_pkg::ADR_SEL;
   always_comb begin
      case (wb_adr_i[4:0])
         fpc_pkg::ADR_CTRL:   rd = ctrl;
         fpc_pkg::ADR_STATUS: rd = {24'h0, estop_latched, guide_light,
                                    executing, remote_mode, settings_mode,
                                    laser_drive_power, laser_enable,
                                    pilot_enable};
         fpc_pkg::ADR_COND:   rd = {29'h0, safety_loop_open,
                                    warning_active, error_active};
         fpc_pkg::ADR_EVENT:  rd = {24'h0, events};
         fpc_pkg::ADR_SEL:    rd = {20'h0, target_knob};
         default:             rd = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= '0;
         ctrl     <= fpc_pkg::CTRL_RESET;
      end else begin
         wb_ack_o <= wb_cyc_i & wb_stb_i & hit & ~wb_ack_o & ~wb_err_o;
         wb_err_o <= wb_cyc_i & wb_stb_i & ~hit & ~wb_ack_o & ~wb_err_o;
         wb_dat_o <= rd;
         if (wb_cyc_i && wb_stb_i && wb_we_i && hit && !wb_ack_o
             && wb_adr_i[4:0] == fpc_pkg::ADR_CTRL) begin
            for (int b = 0; b < 4; b++) begin
               if (wb_sel_i[b]) ctrl[8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // assertions
   a_off_no_emit: assert property (@(posedge clock) disable iff (!rst_n)
      key_pos == fpc_pkg::FPC_KEY_OFF |=> !laser_enable && !pilot_enable)
      else $error("emission while key off");
   a_estop_cut: assert property (@(posedge clock) disable iff (!rst_n)
      estop_pressed |=> !laser_drive_power && !laser_enable)
      else $error("drive alive during emergency stop");
   a_laser_gate: assert property (@(posedge clock) disable iff (!rst_n)
      laser_enable |-> $past(key_pos) == fpc_pkg::FPC_KEY_LASER
         && !$past(safety_loop_open) && !$past(error_active))
      else $error("laser on without permission");
   a_pilot_key: assert property (@(posedge clock) disable iff (!rst_n)
      key_pos == fpc_pkg::FPC_KEY_PILOT && !estop_latched && !estop_pressed
      |=> laser_enable == 1'b0)
      else $error("laser in pilot key position");
   a_resume_seq: assert property (@(posedge clock) disable iff (!rst_n)
      $fell(estop_latched) |-> $past(key_seen_off) && !$past(estop_pressed))
      else $error("resume without key cycle");
   a_error_lamp: assert property (@(posedge clock) disable iff (!rst_n)
      error_active |=> lamps.error)
      else $error("error lamp dark");
   a_warn_lamp: assert property (@(posedge clock) disable iff (!rst_n)
      !warning_active |=> !lamps.warning)
      else $error("warning lamp lit");
   a_run_lamp: assert property (@(posedge clock) disable iff (!rst_n)
      lamps.run == executing)
      else $error("run lamp mismatch");
   a_run_release: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(executing) |-> $past(run_rel) && !$past(settings_mode))
      else $error("start not on release");
   a_pilot_lamp: assert property (@(posedge clock) disable iff (!rst_n)
      !pilot_switch |=> !lamps.pilot && !pilot_enable)
      else $error("pilot lit with switch off");
   a_remote_lamp: assert property (@(posedge clock) disable iff (!rst_n)
      ##1 lamps.remote == $past(remote_mode))
      else $error("remote lamp mismatch");
   a_updown_block: assert property (@(posedge clock) disable iff (!rst_n)
      remote_mode && !settings_mode |=> !events.up && !events.down)
      else $error("selection under remote control");

   c_run: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(executing));
   c_estop: cover property (@(posedge clock) disable iff (!rst_n)
      executing ##1 estop_pressed);
   c_settings: cover property (@(posedge clock) disable iff (!rst_n)
      $rose(settings_mode));
   c_clear: cover property (@(posedge clock) disable iff (!rst_n)
      events.fault_clear);
endmodule // fpc_panel
`default_nettype wire

// file: tb/fpc_operator.sv
`timescale 1ns/10ps
`default_nettype none
module fpc_operator (
   input  wire logic       clock,
   input  wire logic       go,
   input  wire logic [2:0] which,
   input  wire logic [7:0] len,
   output logic      [5:0] buttons,
   output logic            busy
);
   logic [8:0] n;
   // contacts chatter once after first touch, as real keys do
   always @(posedge clock) begin
      if (go && !busy) begin
         busy    <= 1'b1;
         n       <= {1'b0, len} + 9'h002;
         buttons <= 6'h01 << which;
      end else if (busy) begin
         n       <= n - 9'h001;
         busy    <= (n != 9'h001);
         buttons <= (n == 9'h001 || n == {1'b0, len} + 9'h002) ?
                    6'h00 : 6'h01 << which;
      end
   end
   initial begin
      busy    = 1'b0;
      n       = 9'h000;
      buttons = 6'h00;
   end
endmodule // fpc_operator
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic                 clock, rst_n, wb_we_i, wb_cyc_i, wb_stb_i;
   logic [31:0]          wb_adr_i, wb_dat_i, wb_dat_o, rd;
   logic [3:0]           wb_sel_i;
   logic                 wb_ack_o, wb_err_o, bus_err, go, busy;
   logic                 estop_pressed, pilot_switch, safety_loop_open;
   logic                 error_active, warning_active, irradiating;
   fpc_pkg::fpc_key_t    key_pos;
   logic [5:0]           buttons;
   logic [2:0]           which;
   logic [7:0]           len;
   logic [11:0]          target_knob, target_temp, target_power;
   fpc_pkg::fpc_lamps_t  lamps;
   fpc_pkg::fpc_events_t events;
   logic                 laser_drive_power, laser_enable, pilot_enable;
   logic                 settings_mode, remote_mode, executing, guide_light;
   int                   fail_count, cmp_count;
   fpc_pkg::fpc_events_t exp_q[$];

   fpc_panel #(.SETUP_CYC(8), .GUIDE_CYC(16), .DEB_CYC(2)) i_fpc_panel (
      .clock, .rst_n, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i,
      .wb_stb_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .key_pos, .estop_pressed,
      .pilot_switch, .safety_loop_open, .error_active, .warning_active,
      .irradiating, .buttons, .target_knob, .lamps, .events,
      .laser_drive_power, .laser_enable, .pilot_enable, .settings_mode,
      .remote_mode, .executing, .guide_light, .target_temp, .target_power);
   fpc_operator i_fpc_operator (.clock, .go, .which, .len, .buttons, .busy);

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         fail_count++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask

   task automatic end_of_test();
      $display("mismatches %0d compares %0d", fail_count, cmp_count);
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic wb(input logic we, input logic [31:0] a,
                     input logic [31:0] d);
      int i;
      @(posedge clock);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge clock);
         if (wb_ack_o === 1'b1 || wb_err_o === 1'b1) break;
      end
      if (i == 50) begin
         fail_count++;
         end_of_test();
      end
      rd       = wb_dat_o;
      bus_err  = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic start(input int b, input int l);
      @(posedge clock);
      go    <= 1'b1;
      which <= 3'(b);
      len   <= 8'(l);
      @(posedge clock);
      go    <= 1'b0;
   endtask

   // run and guide toggles land a few cycles after release, once debounced
   task automatic done();
      int i;
      for (i = 0; i < 300; i++) begin
         @(posedge clock);
         if (busy === 1'b0) break;
      end
      if (i == 300) begin
         fail_count++;
         end_of_test();
      end
      repeat (8) @(posedge clock);
      #1;
   endtask

   task automatic press(input int b, input int l);
      start(b, l);
      done();
   endtask

   task automatic settle();
      repeat (3) @(posedge clock);
      #1;
   endtask

   task automatic ex(input logic [7:0] v);
      exp_q.push_back(fpc_pkg::fpc_events_t'(v));
   endtask

   always @(posedge clock) begin
      if (rst_n === 1'b1 && events !== '0) begin
         if (exp_q.size() == 0) chk(events, 0);
         else chk(events, exp_q.pop_front());
      end
   end

   initial begin
      logic el, ep;
      rst_n = 1'b0;
      {wb_we_i, wb_cyc_i, wb_stb_i, go, irradiating} = '0;
      {wb_adr_i, wb_dat_i, which, len, target_knob} = '0;
      {estop_pressed, pilot_switch, safety_loop_open} = '0;
      {error_active, warning_active} = '0;
      wb_sel_i = 4'hf;
      key_pos = fpc_pkg::FPC_KEY_OFF;
      fail_count = 0;
      cmp_count = 0;
      void'($urandom(86458));
      repeat (12) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      chk(lamps, 0);
      chk(laser_enable, 0);
      wb(1'b0, 32'(fpc_pkg::ADR_CTRL), 0);
      chk(rd, fpc_pkg::CTRL_RESET);
      wb(1'b0, 32'h14, 0);
      chk(bus_err, 1);
      wb(1'b1, 32'(fpc_pkg::ADR_CTRL), 32'h3);
      wb(1'b0, 32'(fpc_pkg::ADR_CTRL), 0);
      chk(rd, 32'h3);
      @(posedge clock);
      target_knob <= 12'($urandom);
      settle();
      chk(target_temp, target_knob);
      chk(lamps.thermal_mode_lamp, 1);
      chk(lamps.analog, 1);
      wb(1'b1, 32'(fpc_pkg::ADR_CTRL), 32'h4);
      @(posedge clock);
      target_knob <= 12'($urandom);
      settle();
      chk(target_power, target_knob);
      chk(lamps.thermal_mode_lamp, 0);
      chk(lamps.analog, 0);
      for (int k = 0; k < 3; k++)
         for (int m = 0; m < 16; m++) begin
            @(posedge clock);
            key_pos          <= fpc_pkg::fpc_key_t'(k);
            safety_loop_open <= m[0];
            error_active     <= m[1];
            pilot_switch     <= m[2];
            warning_active   <= m[3];
            settle();
            el = (k == 2) && !m[0] && !m[1];
            ep = m[2] && (el || (k == 1 && !m[1]));
            chk(laser_drive_power, el);
            chk(laser_enable, 0);
            chk(pilot_enable, ep);
            chk(lamps.pilot, ep);
            chk(lamps.error, m[1]);
            chk(lamps.warning, m[3]);
            if (!el) chk(lamps.ready, 0);
            if (k == 0) chk(laser_drive_power, 0);
         end
      @(posedge clock);
      {safety_loop_open, error_active, pilot_switch, warning_active} <= '0;
      settle();
      chk(lamps.ready, 1);
      ex(8'h80);
      press(fpc_pkg::B_UP, 4);
      ex(8'h40);
      press(fpc_pkg::B_DOWN, 4);
      for (int r = 1; r >= 0; r--) begin
         ex(8'h20);
         press(fpc_pkg::B_ENTER, 4);
         chk(remote_mode, r);
         chk(lamps.remote, r);
         if (r == 1) press(fpc_pkg::B_UP, 4);
      end
      ex(8'h04);
      start(fpc_pkg::B_RUN, 20);
      repeat (12) @(posedge clock);
      #1;
      chk(executing, 0);
      done();
      chk(executing, 1);
      chk(laser_enable, 1);
      chk(lamps.run, 1);
      @(posedge clock);
      irradiating <= 1'b1;
      settle();
      chk(lamps.laser, 1);
      ex(8'h04);
      @(posedge clock);
      estop_pressed <= 1'b1;
      @(posedge clock);
      #1;
      chk(laser_drive_power, 0);
      chk(laser_enable, 0);
      chk(executing, 0);
      @(posedge clock);
      irradiating   <= 1'b0;
      estop_pressed <= 1'b0;
      settle();
      chk(laser_drive_power, 0);
      chk(lamps.laser, 0);
      @(posedge clock);
      key_pos <= fpc_pkg::FPC_KEY_OFF;
      settle();
      @(posedge clock);
      key_pos <= fpc_pkg::FPC_KEY_LASER;
      settle();
      chk(lamps.ready, 1);
      chk(laser_enable, 0);
      chk(laser_drive_power, 1);
      ex(8'h02);
      press(fpc_pkg::B_GUIDE, 4 + int'($urandom % 4));
      chk(guide_light, 1);
      ex(8'h01);
      press(fpc_pkg::B_GUIDE, 30);
      chk(guide_light, 1);
      press(fpc_pkg::B_SETUP, 20);
      chk(settings_mode, 1);
      press(fpc_pkg::B_RUN, 4);
      chk(executing, 0);
      press(fpc_pkg::B_GUIDE, 4);
      chk(guide_light, 1);
      ex(8'h10);
      press(fpc_pkg::B_ENTER, 4);
      ex(8'h08);
      press(fpc_pkg::B_SETUP, 4);
      chk(settings_mode, 0);
      chk(exp_q.size(), 0);
      end_of_test();
   end
endmodule // tb_top
`default_nettype wire
